// *** pcr_channel.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// one capture channel: one-time and continuous results
// ----------------------------------------------------------------------
module pcr_channel (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // commands and results
  pcr_chan_if.chan ch
);
  pcr_pkg::pcr_mode_t mode_r;     // capture mode
  logic signed [31:0] singlePos_r; // one-time result
  logic signed [31:0] latestPos_r; // newest continuous capture, never read directly
  logic signed [31:0] consPos_r;  // frozen copy handed to the master
  logic [15:0] count_r;           // continuous event counter
  logic flag_r;                   // captured flag
  logic startOnce;                // arm one-time capture
  logic startCont;                // arm continuous capture
  logic stopCmd;                  // cancel capture
  logic onceHit;                  // edge while one-time armed
  logic contHit;                  // edge while continuous armed

  // ----------------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------------
  assign startOnce = ch.actStrobe && (ch.actCode == pcr_pkg::ACT_ONCE);
  assign startCont = ch.actStrobe && (ch.actCode == pcr_pkg::ACT_CONT);
  assign stopCmd = ch.actStrobe && !startOnce && !startCont; // reserved codes stop too
  assign onceHit = ch.capEvent && (mode_r == pcr_pkg::MODE_ONCE);
  assign contHit = ch.capEvent && (mode_r == pcr_pkg::MODE_CONT);

  // mode: a new start wins over an edge in the same cycle
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      mode_r <= pcr_pkg::MODE_IDLE;
    end else if (ch.ce) begin
      if (startOnce) begin
        mode_r <= pcr_pkg::MODE_ONCE;
      end else if (startCont) begin
        mode_r <= pcr_pkg::MODE_CONT;
      end else if (stopCmd) begin
        mode_r <= pcr_pkg::MODE_IDLE;
      end else if (onceHit) begin
        mode_r <= pcr_pkg::MODE_IDLE;
      end
    end
  end

  // one-time result, moved with the frame
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      singlePos_r <= pcr_pkg::POS_RST;
    end else if (ch.ce) begin
      if (onceHit) begin
        singlePos_r <= ch.motorPos;
      end else if (ch.frameShift) begin
        singlePos_r <= singlePos_r + ch.frameDelta;
      end
    end
  end

  // newest continuous capture; each edge overwrites the last
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      latestPos_r <= pcr_pkg::POS_RST;
    end else if (ch.ce) begin
      if (contHit) begin
        latestPos_r <= ch.motorPos;
      end else if (ch.frameShift) begin
        latestPos_r <= latestPos_r + ch.frameDelta;
      end
    end
  end

  // frozen copy: only a counter read refreshes it, so pairs stay consistent
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      consPos_r <= pcr_pkg::POS_RST;
    end else if (ch.ce) begin
      if (ch.readCount) begin
        // old latest matches the count value read in this cycle
        consPos_r <= ch.frameShift ? latestPos_r + ch.frameDelta : latestPos_r;
      end else if (ch.frameShift) begin
        consPos_r <= consPos_r + ch.frameDelta;
      end
    end
  end

  // event counter keeps counting while the copy is frozen
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      count_r <= pcr_pkg::CNT_RST;
    end else if (ch.ce) begin
      if (startCont) begin
        count_r <= pcr_pkg::CNT_RST;
      end else if (contHit) begin
        count_r <= count_r + pcr_pkg::CNT_ONE; // wraps at 16 bits
      end
    end
  end

  // captured flag: an edge wins over the clear on activation
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      flag_r <= 1'b0;
    end else if (ch.ce) begin
      if (onceHit || contHit) begin
        flag_r <= 1'b1;
      end else if (startOnce || startCont) begin
        flag_r <= 1'b0;
      end
    end
  end

  assign ch.singlePos = singlePos_r;
  assign ch.consPos = consPos_r;
  assign ch.count = count_r;
  assign ch.flag = flag_r;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  a_once_ends: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    ch.ce && onceHit && !ch.actStrobe |=> mode_r == pcr_pkg::MODE_IDLE && !onceHit)
    else $error("one-time capture did not end");
  a_once_value: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    ch.ce && onceHit |=> singlePos_r == $past(ch.motorPos))
    else $error("one-time position not latched");
  a_count_clear: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    ch.ce && startCont |=> count_r == pcr_pkg::CNT_RST)
    else $error("counter not cleared on activation");
  a_count_incr: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    ch.ce && contHit && !startCont |=> count_r == $past(count_r) + pcr_pkg::CNT_ONE)
    else $error("counter missed an event");
  a_copy_frozen: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    !(ch.ce && (ch.readCount || ch.frameShift)) |=> $stable(consPos_r))
    else $error("frozen position changed without a read");
  a_copy_snapshot: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    ch.ce && ch.readCount && !ch.frameShift |=> consPos_r == $past(latestPos_r))
    else $error("counter read did not refresh position");
  a_frame_shift: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    ch.ce && ch.frameShift && !onceHit |=>
      singlePos_r == $past(singlePos_r) + $past(ch.frameDelta))
    else $error("one-time position not moved with frame");
endmodule : pcr_channel

// *** pcr_pkg.sv ***
// ----------------------------------------------------------------------
// position capture readout constants
// ----------------------------------------------------------------------
package pcr_pkg;
  // parameter addresses seen by the fieldbus master
  localparam logic [15:0] ADDR_FLAGS = 16'h0a02;   // capture flags word
  localparam logic [15:0] ADDR_SINGLE1 = 16'h0a0c; // one-time result, input one
  localparam logic [15:0] ADDR_SINGLE2 = 16'h0a0e; // one-time result, input two
  localparam logic [15:0] ADDR_COUNT1 = 16'h0a2e;  // continuous counter, input one
  localparam logic [15:0] ADDR_CONS1 = 16'h0a30;   // continuous position, input one
  localparam logic [15:0] ADDR_COUNT2 = 16'h0a32;  // continuous counter, input two
  localparam logic [15:0] ADDR_CONS2 = 16'h0a34;   // continuous position, input two

  // widths
  localparam int POS_W = 32;  // signed position
  localparam int CNT_W = 16;  // event counter
  localparam int ACT_W = 3;   // start/stop code
  localparam int ADDR_W = 16; // parameter address

  // start/stop codes; anything else stops capture
  localparam logic [2:0] ACT_STOP = 3'h0;
  localparam logic [2:0] ACT_ONCE = 3'h1;
  localparam logic [2:0] ACT_CONT = 3'h2;

  // flags word bit positions
  localparam int FLAG1_BIT = 0;
  localparam int FLAG2_BIT = 1;

  // reset values
  localparam logic [31:0] POS_RST = 32'h0;
  localparam logic [15:0] CNT_RST = 16'h0;
  localparam logic [15:0] CNT_ONE = 16'h1;
  localparam logic [31:0] DATA_RST = 32'h0;

  // channel capture mode
  typedef enum logic [1:0] {
    MODE_IDLE,
    MODE_ONCE,
    MODE_CONT
  } pcr_mode_t;

  // decoded read target
  typedef enum logic [2:0] {
    SEL_NONE,
    SEL_FLAGS,
    SEL_SINGLE1,
    SEL_SINGLE2,
    SEL_COUNT1,
    SEL_CONS1,
    SEL_COUNT2,
    SEL_CONS2
  } pcr_sel_t;
endpackage : pcr_pkg

// *** pcr_chan_if.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// link between readout top and one capture channel
// ----------------------------------------------------------------------
interface pcr_chan_if;
  logic ce;                       // clock enable
  logic actStrobe;                // start/stop command valid
  logic [2:0] actCode;            // start/stop code
  logic capEvent;                 // qualified capture edge
  logic readCount;                // counter is being read
  logic frameShift;               // coordinate frame changed
  logic signed [31:0] frameDelta; // new frame minus old frame
  logic signed [31:0] motorPos;   // live motor position
  logic signed [31:0] singlePos;  // one-time result
  logic signed [31:0] consPos;    // frozen continuous result
  logic [15:0] count;             // continuous event counter
  logic flag;                     // position captured

  // top drives commands, reads results
  modport ctrl (
    output ce, actStrobe, actCode, capEvent, readCount, frameShift, frameDelta, motorPos,
    input singlePos, consPos, count, flag
  );
  // channel takes commands, returns results
  modport chan (
    input ce, actStrobe, actCode, capEvent, readCount, frameShift, frameDelta, motorPos,
    output singlePos, consPos, count, flag
  );
endinterface : pcr_chan_if

// *** pcr_position_capture.sv ***
`timescale 1ns/1ps
module pcr_position_capture (
  // clock, reset, enable
  input wire logic clk_sys,
  input wire logic nrst,
  input wire logic ce,
  // position source and frame changes
  input wire logic signed [31:0] motorPos,
  input wire logic frameShift,
  input wire logic signed [31:0] frameDelta,
  // input one: qualified edge and start/stop
  input wire logic capEvent1,
  input wire logic actStrobe1,
  input wire logic [2:0] actCode1,
  // input two: qualified edge and start/stop
  input wire logic capEvent2,
  input wire logic actStrobe2,
  input wire logic [2:0] actCode2,
  // parameter read port
  input wire logic rdReq,
  input wire logic [15:0] rdAddr,
  output logic [31:0] rdData,
  output logic rdValid,
  output logic rdErr,
  // status to the rest of the capture unit
  output logic [1:0] capFlags
);
  pcr_chan_if ch1 (); // input one channel link
  pcr_chan_if ch2 (); // input two channel link
  pcr_pkg::pcr_sel_t rdSel; // decoded read target
  logic [31:0] rdData_r;    // read answer
  logic rdValid_r;          // answer valid
  logic rdErr_r;            // unmapped address
  logic [1:0] capFlags_r;   // registered flags

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  function automatic pcr_pkg::pcr_sel_t decodeAddr(input logic [15:0] addr);
    case (addr)
      pcr_pkg::ADDR_FLAGS: decodeAddr = pcr_pkg::SEL_FLAGS;
      pcr_pkg::ADDR_SINGLE1: decodeAddr = pcr_pkg::SEL_SINGLE1;
      pcr_pkg::ADDR_SINGLE2: decodeAddr = pcr_pkg::SEL_SINGLE2;
      pcr_pkg::ADDR_COUNT1: decodeAddr = pcr_pkg::SEL_COUNT1;
      pcr_pkg::ADDR_CONS1: decodeAddr = pcr_pkg::SEL_CONS1;
      pcr_pkg::ADDR_COUNT2: decodeAddr = pcr_pkg::SEL_COUNT2;
      pcr_pkg::ADDR_CONS2: decodeAddr = pcr_pkg::SEL_CONS2;
      default: decodeAddr = pcr_pkg::SEL_NONE;
    endcase
  endfunction : decodeAddr

  assign rdSel = rdReq ? decodeAddr(rdAddr) : pcr_pkg::SEL_NONE;

  // ----------------------------------------------------------------------
  // channel hookup
  // ----------------------------------------------------------------------
  assign ch1.ce = ce;
  assign ch1.actStrobe = actStrobe1;
  assign ch1.actCode = actCode1;
  assign ch1.capEvent = capEvent1;
  // the copy is refreshed by the counter read, so reading position first gives a stale pair
  assign ch1.readCount = (rdSel == pcr_pkg::SEL_COUNT1);
  assign ch1.frameShift = frameShift;
  assign ch1.frameDelta = frameDelta;
  assign ch1.motorPos = motorPos;

  assign ch2.ce = ce;
  assign ch2.actStrobe = actStrobe2;
  assign ch2.actCode = actCode2;
  assign ch2.capEvent = capEvent2;
  assign ch2.readCount = (rdSel == pcr_pkg::SEL_COUNT2);
  assign ch2.frameShift = frameShift;
  assign ch2.frameDelta = frameDelta;
  assign ch2.motorPos = motorPos;

  // input one results
  pcr_channel uChan1 (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .ch(ch1.chan)
  );

  // input two results, same logic: counter clear and freeze included
  pcr_channel uChan2 (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .ch(ch2.chan)
  );

  // ----------------------------------------------------------------------
  // read answer
  // ----------------------------------------------------------------------
  // data one cycle after the request; all targets are read-only
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdData_r <= pcr_pkg::DATA_RST;
    end else if (ce && rdReq) begin
      case (rdSel)
        pcr_pkg::SEL_FLAGS: begin
          rdData_r <= pcr_pkg::DATA_RST;
          rdData_r[pcr_pkg::FLAG1_BIT] <= ch1.flag;
          rdData_r[pcr_pkg::FLAG2_BIT] <= ch2.flag;
        end
        pcr_pkg::SEL_SINGLE1: rdData_r <= ch1.singlePos;
        pcr_pkg::SEL_SINGLE2: rdData_r <= ch2.singlePos;
        pcr_pkg::SEL_COUNT1: rdData_r <= {pcr_pkg::CNT_RST, ch1.count};
        pcr_pkg::SEL_CONS1: rdData_r <= ch1.consPos;
        pcr_pkg::SEL_COUNT2: rdData_r <= {pcr_pkg::CNT_RST, ch2.count};
        pcr_pkg::SEL_CONS2: rdData_r <= ch2.consPos;
        default: rdData_r <= pcr_pkg::DATA_RST; // unmapped reads zero
      endcase
    end
  end

  // answer strobe and error mark
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdValid_r <= 1'b0;
      rdErr_r <= 1'b0;
    end else if (ce) begin
      rdValid_r <= rdReq;
      rdErr_r <= rdReq && (rdSel == pcr_pkg::SEL_NONE);
    end
  end

  // flags for the surrounding unit
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      capFlags_r <= 2'h0;
    end else if (ce) begin
      capFlags_r <= {ch2.flag, ch1.flag};
    end
  end

  assign rdData = rdData_r;
  assign rdValid = rdValid_r;
  assign rdErr = rdErr_r;
  assign capFlags = capFlags_r;

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  a_read_answer: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    ce && rdReq |=> rdValid_r && (rdErr_r == ($past(rdSel) == pcr_pkg::SEL_NONE)))
    else $error("read not answered next cycle");
  a_flags_word: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    ce && rdReq && rdAddr == pcr_pkg::ADDR_FLAGS |=>
      rdData_r == {30'h0, $past(ch2.flag), $past(ch1.flag)})
    else $error("flags word wrong");
  a_pair_consistent: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    ce && rdReq && rdAddr == pcr_pkg::ADDR_COUNT2 && !frameShift |=>
      rdData_r[31:16] == 16'h0 && ch2.consPos == $past(uChan2.latestPos_r))
    else $error("counter and position of input two not paired");
  // enable low must hold every registered output
  a_ce_freeze: assert property (
    @(posedge clk_sys) disable iff (!nrst)
    !ce |=> $stable(rdData_r) && $stable(rdValid_r) && $stable(rdErr_r) && $stable(capFlags_r))
    else $error("outputs moved while enable was low");
endmodule : pcr_position_capture

// *** pcr_bus_master.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// fieldbus master issuing parameter reads
// ----------------------------------------------------------------------
module pcr_bus_master (
  // clock
  input wire logic clk_sys,
  // read port toward the readout
  output logic rdReq,
  output logic [15:0] rdAddr,
  input wire logic [31:0] rdData,
  input wire logic rdValid,
  input wire logic rdErr
);
  // idle: no request, address parked
  initial begin
    rdReq = 1'b0;
    rdAddr = 16'hffff;
  end

  // one read: raised after the next edge, taken at the edge after, answer stands right after that taking edge
  task automatic rd(input logic [15:0] addr, output logic [31:0] data, output logic err);
    int waitN;
    @(posedge clk_sys);
    #1;
    rdReq = 1'b1;
    rdAddr = addr;
    @(posedge clk_sys);
    #1;
    // a held request would be taken twice, so drop it right after the taking edge
    rdReq = 1'b0;
    rdAddr = ~addr; // released address must not look valid
    waitN = 0;
    while (rdValid !== 1'b1 && waitN < 8) begin
      @(posedge clk_sys);
      #1;
      waitN++;
    end
    data = (rdValid === 1'b1) ? rdData : 32'hxxxxxxxx;
    err = (rdValid === 1'b1) ? rdErr : 1'bx;
  endtask : rd

  // consistent pair: counter first, it refreshes the position copy
  task automatic rdPair(input logic [15:0] cntA, input logic [15:0] posA,
    output logic [31:0] cntV, output logic [31:0] posV);
    logic e;
    rd(cntA, cntV, e);
    rd(posA, posV, e);
  endtask : rdPair
endmodule : pcr_bus_master

// *** pcr_position_capture_tb.sv ***
`timescale 1ns/1ps
// ----------------------------------------------------------------------
// self-checking bench for the capture readout
// ----------------------------------------------------------------------
module pcr_position_capture_tb;
  // clock, reset, stimulus
  logic clk_sys;
  logic nrst;
  logic ce; // low only in the freeze scenario
  logic signed [31:0] motorPos;
  logic frameShift;
  logic signed [31:0] frameDelta;
  logic [1:0] capEv;
  logic [1:0] actStb;
  logic [2:0] actCode1;
  logic [2:0] actCode2;
  // read port
  logic rdReq;
  logic [15:0] rdAddr;
  logic [31:0] rdData;
  logic rdValid;
  logic rdErr;
  logic [1:0] capFlags;
  // bookkeeping
  int error_cnt;
  int checks;
  int seed;
  // reference model, one slot per input
  logic [31:0] single[2];
  logic [31:0] latest[2];
  logic [31:0] cons[2];
  logic [15:0] cnt[2];
  int mode[2]; // 0 idle, 1 once, 2 continuous
  logic flg[2];

  pcr_position_capture dut_u (
    .clk_sys(clk_sys), .nrst(nrst), .ce(ce), .motorPos(motorPos),
    .frameShift(frameShift), .frameDelta(frameDelta),
    .capEvent1(capEv[0]), .actStrobe1(actStb[0]), .actCode1(actCode1),
    .capEvent2(capEv[1]), .actStrobe2(actStb[1]), .actCode2(actCode2),
    .rdReq(rdReq), .rdAddr(rdAddr), .rdData(rdData), .rdValid(rdValid),
    .rdErr(rdErr), .capFlags(capFlags)
  );
  pcr_bus_master bm_u (
    .clk_sys(clk_sys), .rdReq(rdReq), .rdAddr(rdAddr), .rdData(rdData),
    .rdValid(rdValid), .rdErr(rdErr)
  );

  // 200 MHz clock
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask : tick

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  task automatic stop_test();
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : stop_test

  // expected answer {err, data}; counter reads refresh the frozen copy
  function automatic logic [32:0] modelRd(input logic [15:0] a);
    case (a)
      pcr_pkg::ADDR_FLAGS: return {3'h0, 28'h0, flg[1], flg[0]};
      pcr_pkg::ADDR_SINGLE1: return {1'b0, single[0]};
      pcr_pkg::ADDR_SINGLE2: return {1'b0, single[1]};
      pcr_pkg::ADDR_COUNT1: begin
        cons[0] = latest[0];
        return {17'h0, cnt[0]};
      end
      pcr_pkg::ADDR_COUNT2: begin
        cons[1] = latest[1];
        return {17'h0, cnt[1]};
      end
      pcr_pkg::ADDR_CONS1: return {1'b0, cons[0]};
      pcr_pkg::ADDR_CONS2: return {1'b0, cons[1]};
      default: return {1'b1, 32'h0};
    endcase
  endfunction : modelRd

  // read through the master and predict it
  task automatic xr(input logic [15:0] a, output logic [31:0] got, output logic [31:0] exp);
    logic e;
    logic [32:0] m;
    bm_u.rd(a, got, e);
    m = modelRd(a);
    exp = m[31:0];
    chk({31'h0, e}, {31'h0, m[32]});
  endtask : xr

  // start/stop command on one input
  task automatic act(input int c, input logic [2:0] code);
    tick();
    actStb[c] = 1'b1;
    if (c == 0) actCode1 = code;
    else actCode2 = code;
    tick();
    actStb[c] = 1'b0;
    mode[c] = (code == pcr_pkg::ACT_ONCE) ? 1 : (code == pcr_pkg::ACT_CONT) ? 2 : 0;
    if (mode[c] != 0) flg[c] = 1'b0; // start clears the flag
    if (mode[c] == 2) cnt[c] = 16'h0;
  endtask : act

  // one qualified capture edge
  task automatic ev(input int c, input logic [31:0] p);
    tick();
    motorPos = p;
    capEv[c] = 1'b1;
    tick();
    capEv[c] = 1'b0;
    if (mode[c] == 1) begin
      single[c] = p;
      mode[c] = 0;
      flg[c] = 1'b1;
    end else if (mode[c] == 2) begin
      latest[c] = p;
      cnt[c] = cnt[c] + 16'h1;
      flg[c] = 1'b1;
    end
  endtask : ev

  // coordinate frame change moves every stored position
  task automatic shift(input logic [31:0] d);
    tick();
    frameShift = 1'b1;
    frameDelta = d;
    tick();
    frameShift = 1'b0;
    for (int c = 0; c < 2; c++) begin
      single[c] = single[c] + d;
      latest[c] = latest[c] + d;
      cons[c] = cons[c] + d;
    end
  endtask : shift

  // ----------------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------------
  initial begin
    logic [31:0] got;
    logic [31:0] got2;
    logic [31:0] exp;
    logic [32:0] m;
    int n;
    logic [15:0] addrs[$];
    logic [2:0] codes[$];
    logic [15:0] cntA[2];
    logic [15:0] posA[2];
    addrs = '{pcr_pkg::ADDR_FLAGS, pcr_pkg::ADDR_SINGLE1, pcr_pkg::ADDR_SINGLE2,
      pcr_pkg::ADDR_COUNT1, pcr_pkg::ADDR_CONS1, pcr_pkg::ADDR_COUNT2,
      pcr_pkg::ADDR_CONS2, 16'h0a04};
    codes = '{3'h0, 3'h3, 3'h4, 3'h5, 3'h6, 3'h7};
    cntA = '{pcr_pkg::ADDR_COUNT1, pcr_pkg::ADDR_COUNT2};
    posA = '{pcr_pkg::ADDR_CONS1, pcr_pkg::ADDR_CONS2};
    seed = 34572;
    error_cnt = 0;
    checks = 0;
    nrst = 1'b0;
    ce = 1'b1;
    motorPos = 32'h0;
    frameShift = 1'b0;
    frameDelta = 32'h0;
    capEv = 2'h0;
    actStb = 2'h0;
    actCode1 = 3'h0;
    actCode2 = 3'h0;
    for (int c = 0; c < 2; c++) begin
      single[c] = 32'h0;
      latest[c] = 32'h0;
      cons[c] = 32'h0;
      cnt[c] = 16'h0;
      mode[c] = 0;
      flg[c] = 1'b0;
    end
    repeat (2) @(posedge clk_sys);
    #1;
    nrst = 1'b1;
    // all results zero after reset; a gap address answers with an error
    foreach (addrs[i]) begin
      xr(addrs[i], got, exp);
      chk(got, exp);
    end
    // one-time capture: second edge must leave the result alone
    for (int c = 0; c < 2; c++) begin
      act(c, pcr_pkg::ACT_ONCE);
      ev(c, $random(seed));
      ev(c, $random(seed));
    end
    xr(pcr_pkg::ADDR_SINGLE1, got, exp);
    chk(got, exp);
    xr(pcr_pkg::ADDR_SINGLE2, got, exp);
    chk(got, exp);
    xr(pcr_pkg::ADDR_FLAGS, got, exp);
    chk(got, exp);
    chk({30'h0, capFlags}, {30'h0, flg[1], flg[0]});
    // continuous capture per input
    for (int c = 0; c < 2; c++) begin
      act(c, pcr_pkg::ACT_CONT);
      n = 1 + ($unsigned($random(seed)) % 4);
      repeat (n) ev(c, $random(seed));
      xr(posA[c], got, exp);
      chk(got, exp);
      xr(cntA[c], got, exp);
      chk(got, exp);
      xr(posA[c], got, exp);
      chk(got, exp);
      repeat (n) ev(c, $random(seed));
      xr(posA[c], got, exp);
      chk(got, exp);
      shift($random(seed));
      xr(pcr_pkg::ADDR_SINGLE1, got, exp);
      chk(got, exp);
      xr(posA[c], got, exp);
      chk(got, exp);
      bm_u.rdPair(cntA[c], posA[c], got, got2);
      m = modelRd(cntA[c]);
      chk(got, m[31:0]);
      m = modelRd(posA[c]);
      chk(got2, m[31:0]);
      act(c, pcr_pkg::ACT_CONT);
      xr(cntA[c], got, exp);
      chk(got, exp);
    end
    // stop and reserved codes end capture: counter stays cleared
    foreach (codes[i]) begin
      act(0, pcr_pkg::ACT_CONT);
      act(0, codes[i]);
      ev(0, $random(seed));
      xr(pcr_pkg::ADDR_COUNT1, got, exp);
      chk(got, exp);
    end
    // enable low: an edge in that window must not count on input two
    tick();
    ce = 1'b0;
    capEv[1] = 1'b1;
    motorPos = $random(seed);
    tick();
    capEv[1] = 1'b0;
    ce = 1'b1;
    xr(pcr_pkg::ADDR_COUNT2, got, exp);
    chk(got, exp);
    // enable back high: the next edge counts again
    ev(1, $random(seed));
    xr(pcr_pkg::ADDR_COUNT2, got, exp);
    chk(got, exp);
    xr(pcr_pkg::ADDR_CONS2, got, exp);
    chk(got, exp);
    stop_test();
  end

  // hang guard: the sequence needs well under a thousand cycles
  initial begin
    #100000;
    error_cnt++;
    stop_test();
  end
endmodule : pcr_position_capture_tb
